// [hdl/fsp_section_ctrl.sv]
// Functional notes
// - Store instruction acts only from boot section
// - Boot code may target any flash address
// - Boot boundary set by boot size fuses
// - Two independent lock sets, application and boot
// - Fixed concurrent-read and stalling section split
// - Target address alone picks concurrent or halting
// - Concurrent-section operation keeps core running
// - Stalling-section operation halts core, nothing readable
// - Boot section lies inside stalling section
// - Busy flag reads one while section blocked
// - Hardware sets busy on concurrent-section erase/write
// - Busy cleared by read enable or page load
//
// Added by the designer: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module fsp_section_ctrl #(
  parameter int FLASH_WORDS    = 16384, // Flash size in words
  parameter int STALL_WORDS    = 2048,  // Stalling section size, top
  parameter int BOOT_MIN_WORDS = 256,   // Boot size at fuse code 3
  parameter int PROG_CYCLES    = fsp_pkg::PROG_CYCLES // Operation length
) (
  input  wire logic                  clk,        // Core clock
  input  wire logic                  sys_rst,    // Synchronous reset
  // AXI4-Lite slave
  input  wire logic [4:0]            awaddr,     // Write address
  input  wire logic                  awvalid,    // Write address valid
  output logic                       awready,    // Write address ready
  input  wire logic [31:0]           wdata,      // Write data
  input  wire logic [3:0]            wstrb,      // Write strobes
  input  wire logic                  wvalid,     // Write data valid
  output logic                       wready,     // Write data ready
  output logic [1:0]                 bresp,      // Write response
  output logic                       bvalid,     // Write response valid
  input  wire logic                  bready,     // Write response ready
  input  wire logic [4:0]            araddr,     // Read address
  input  wire logic                  arvalid,    // Read address valid
  output logic                       arready,    // Read address ready
  output logic [31:0]                rdata,      // Read data
  output logic [1:0]                 rresp,      // Read response
  output logic                       rvalid,     // Read data valid
  input  wire logic                  rready,     // Read data ready
  // Core side
  input  wire logic                  storeValid, // Store instruction pulse
  input  wire fsp_pkg::fsp_store_t   storeInsn,  // Store instruction fields
  input  wire logic [1:0]            bootSizeFuses, // Fuse pins
  output logic                       coreHalt,   // Stall the core
  output logic                       concurrentSectionBusy, // Reads blocked
  output fsp_pkg::fsp_flash_cmd_t    flashCmd,   // Flash array command
  output logic                       irq         // Level interrupt
);
  localparam int AW = 16; // Address width

  // Refuse maps the logic cannot serve, at elaboration
  if (FLASH_WORDS > (1 << AW) || STALL_WORDS > FLASH_WORDS)
  begin : gBadMap
    $error("Flash map does not fit the address width");
  end
  if (BOOT_MIN_WORDS * 8 > STALL_WORDS)
  begin : gBadBoot
    $error("Largest boot section must lie in stalling section");
  end

  // First word of the boot section for a fuse code
  function automatic logic [AW-1:0] bootStart(input logic [1:0] fuse);
    int words;
    words = BOOT_MIN_WORDS << (2'd3 - fuse);
    return AW'(FLASH_WORDS - words);
  endfunction

  // Address lies in the boot section
  function automatic logic inBoot(input logic [AW-1:0] a,
                                  input logic [1:0] fuse);
    return a >= bootStart(fuse);
  endfunction

  // Address lies in the fixed stalling section
  function automatic logic inStall(input logic [AW-1:0] a);
    return a >= AW'(FLASH_WORDS - STALL_WORDS);
  endfunction

  // Fuse pin synchroniser and capture
  logic [1:0] fuseMeta;   // First stage
  logic [1:0] fuseSync;   // Second stage
  logic [1:0] bootFuse;   // Captured fuse code
  logic       fuseLoaded; // Capture done
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      fuseMeta <= 2'h3;
      fuseSync <= 2'h3;
    end
    else
    begin
      fuseMeta <= bootSizeFuses;
      fuseSync <= fuseMeta;
    end
  end

  // Fuses held steady once captured after reset
  logic [1:0] fuseWait; // Edges until second stage holds the pins
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      bootFuse   <= 2'h3;
      fuseLoaded <= 1'b0;
      fuseWait   <= 2'h0;
    end
    else if (fuseWait != 2'h2)
      fuseWait <= fuseWait + 2'h1; // Pins still crossing both stages
    else if (!fuseLoaded)
    begin
      bootFuse   <= fuseSync;
      fuseLoaded <= 1'b1;
    end
  end

  // Registers and state
  logic [fsp_pkg::CTRL_W-1:0] ctrl;     // Control register
  logic [3:0]                 lockBits; // [1:0] application, [3:2] boot
  logic [fsp_pkg::EV_W-1:0]   irqStat;  // Sticky events
  logic [fsp_pkg::EV_W-1:0]   irqMask;  // Event enables
  logic                       opActive; // Erase or write running
  logic                       opDone;   // Timer finish pulse

  // Store instruction decode
  logic          armed;     // Control armed
  logic          fromBoot;  // Executing inside boot section
  logic          tgtBoot;   // Target inside boot section
  logic          tgtStall;  // Target inside stalling section
  logic          lockOk;    // Target section writable
  logic          doProg;    // Start erase or write
  logic          doLoad;    // Page load
  logic          doReadEn;  // Read enable
  logic          doLock;    // Lock programming
  logic          reject;    // Refused store instruction
  logic          storeTaken; // Store instruction consumed armed control

  // Decode the store instruction against sections and locks
  always_comb
  begin
    armed    = ctrl[fsp_pkg::CTRL_ARM] && fuseLoaded;
    fromBoot = inBoot(storeInsn.pc, bootFuse);
    tgtBoot  = inBoot(storeInsn.z, bootFuse);
    tgtStall = inStall(storeInsn.z);
    lockOk   = tgtBoot ? lockBits[2] : lockBits[0];
    storeTaken = storeValid && armed && !opActive;
    doProg   = 1'b0;
    doLoad   = 1'b0;
    doReadEn = 1'b0;
    doLock   = 1'b0;
    reject   = storeValid && armed && (opActive || !fromBoot);
    if (storeTaken && fromBoot)
    begin
      if (ctrl[fsp_pkg::CTRL_ERASE] || ctrl[fsp_pkg::CTRL_WRITE])
      begin
        doProg = lockOk;
        reject = !lockOk;
      end
      else if (ctrl[fsp_pkg::CTRL_LOCKSET])
        doLock = 1'b1;
      else if (ctrl[fsp_pkg::CTRL_READEN])
        doReadEn = 1'b1;
      else
        doLoad = 1'b1;
    end
  end

  // Programming time
  fsp_op_timer #(
    .CYCLES (PROG_CYCLES)
  ) uTimer (
    .clk     (clk),
    .sys_rst (sys_rst),
    .start   (doProg),
    .done    (opDone)
  );

  // Operation state, halt and flash strobes
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      opActive <= 1'b0;
      coreHalt <= 1'b0;
      flashCmd <= '0;
    end
    else
    begin
      flashCmd.erase <= doProg && ctrl[fsp_pkg::CTRL_ERASE];
      flashCmd.write <= doProg && !ctrl[fsp_pkg::CTRL_ERASE];
      if (doProg)
      begin
        flashCmd.addr <= storeInsn.z;
        opActive      <= 1'b1;
        coreHalt      <= tgtStall;
      end
      else if (opDone)
      begin
        opActive <= 1'b0;
        coreHalt <= 1'b0;
      end
    end
  end

  // Concurrent section busy flag
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      concurrentSectionBusy <= 1'b0;
    else if (doProg && !tgtStall)
      concurrentSectionBusy <= 1'b1;
    else if (doReadEn || doLoad)
      concurrentSectionBusy <= 1'b0;
  end

  // Lock bits may only be programmed by a store; only reset erases them here
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      lockBits <= fsp_pkg::LOCK_RST;
    else if (doLock)
      lockBits <= lockBits & storeInsn.data[5:2];
  end

  // AXI write channel capture
  logic [4:0] awHold;  // Held write address
  logic       awHave;  // Address taken
  logic [31:0] wHold;  // Held write data
  logic [3:0] wsHold;  // Held strobes
  logic       wHave;   // Data taken
  logic       wrFire;  // Perform the write
  assign wrFire = awHave && wHave && !bvalid;

  // Take address and data in either order
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      awHave <= 1'b0;
      wHave  <= 1'b0;
      awHold <= '0;
      wHold  <= '0;
      wsHold <= '0;
    end
    else
    begin
      if (awvalid && awready)
      begin
        awHold <= awaddr;
        awHave <= 1'b1;
      end
      else if (wrFire)
        awHave <= 1'b0;
      if (wvalid && wready)
      begin
        wHold  <= wdata;
        wsHold <= wstrb;
        wHave  <= 1'b1;
      end
      else if (wrFire)
        wHave <= 1'b0;
    end
  end

  // Ready while the holding slot is free
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      awready <= 1'b0;
      wready  <= 1'b0;
    end
    else
    begin
      awready <= !awHave && !(awvalid && awready) && !bvalid;
      wready  <= !wHave && !(wvalid && wready) && !bvalid;
    end
  end

  // Write response
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      bvalid <= 1'b0;
      bresp  <= fsp_pkg::RESP_OKAY;
    end
    else if (wrFire)
    begin
      bvalid <= 1'b1;
      bresp  <= (awHold == fsp_pkg::REG_CTRL ||
                 awHold == fsp_pkg::REG_IRQ_MASK ||
                 awHold == fsp_pkg::REG_STATUS ||
                 awHold == fsp_pkg::REG_IRQ_STAT) ?
                fsp_pkg::RESP_OKAY : fsp_pkg::RESP_DECERR;
    end
    else if (bready)
      bvalid <= 1'b0;
  end

  // Control register; consumed by a taken store instruction
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      ctrl <= fsp_pkg::CTRL_RST;
    else if (wrFire && awHold == fsp_pkg::REG_CTRL && wsHold[0])
      ctrl <= wHold[fsp_pkg::CTRL_W-1:0];
    else if (storeTaken)
      ctrl <= fsp_pkg::CTRL_RST;
  end

  // Interrupt mask register
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      irqMask <= fsp_pkg::MASK_RST;
    else if (wrFire && awHold == fsp_pkg::REG_IRQ_MASK && wsHold[0])
      irqMask <= wHold[fsp_pkg::EV_W-1:0];
  end

  // Read channel
  logic rdTake; // Read address accepted
  assign rdTake = arvalid && arready;
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      arready <= 1'b0;
    else
      arready <= !rvalid && !rdTake;
  end

  // Read data mux
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      rvalid <= 1'b0;
      rdata  <= '0;
      rresp  <= fsp_pkg::RESP_OKAY;
    end
    else if (rdTake)
    begin
      rvalid <= 1'b1;
      rresp  <= fsp_pkg::RESP_OKAY;
      rdata  <= '0;
      case (araddr)
        fsp_pkg::REG_CTRL:
          rdata[fsp_pkg::CTRL_W-1:0] <= ctrl;
        fsp_pkg::REG_STATUS:
        begin
          rdata[fsp_pkg::ST_BUSY]   <= concurrentSectionBusy;
          rdata[fsp_pkg::ST_ACTIVE] <= opActive;
          rdata[fsp_pkg::ST_HALT]   <= coreHalt;
          rdata[fsp_pkg::ST_FUSE +: 2] <= bootFuse;
          rdata[fsp_pkg::ST_LOCK +: 4] <= lockBits;
        end
        fsp_pkg::REG_IRQ_STAT:
          rdata[fsp_pkg::EV_W-1:0] <= irqStat;
        fsp_pkg::REG_IRQ_MASK:
          rdata[fsp_pkg::EV_W-1:0] <= irqMask;
        default:
          rresp <= fsp_pkg::RESP_DECERR;
      endcase
    end
    else if (rready)
      rvalid <= 1'b0;
  end

  // Sticky events; a new event wins over the read clear
  logic [fsp_pkg::EV_W-1:0] evNow; // Events this cycle
  always_comb
  begin
    evNow = '0;
    evNow[fsp_pkg::EV_DONE]   = opDone;
    evNow[fsp_pkg::EV_REJECT] = reject;
  end
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      irqStat <= '0;
    else if (rdTake && araddr == fsp_pkg::REG_IRQ_STAT)
      irqStat <= evNow;
    else
      irqStat <= irqStat | evNow;
  end

  // Interrupt output
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      irq <= 1'b0;
    else
      irq <= |((irqStat | evNow) & irqMask);
  end
endmodule // fsp_section_ctrl
`default_nettype wire

// [hdl/fsp_pkg.sv]
// Shared constants and types for the flash self-program section controller
`default_nettype none
package fsp_pkg;
  // Register byte offsets
  localparam logic [4:0] REG_CTRL      = 5'h00; // Operation select, armed
  localparam logic [4:0] REG_STATUS    = 5'h04; // Busy, halt, fuses, locks
  localparam logic [4:0] REG_IRQ_STAT  = 5'h08; // Sticky events, read clears
  localparam logic [4:0] REG_IRQ_MASK  = 5'h0C; // Event enables
  // Control field positions
  localparam int CTRL_ARM     = 0; // Next store instruction acts
  localparam int CTRL_ERASE   = 1; // Page erase
  localparam int CTRL_WRITE   = 2; // Page write
  localparam int CTRL_LOCKSET = 3; // Program lock bits
  localparam int CTRL_READEN  = 4; // Concurrent section read enable
  localparam int CTRL_W       = 5; // Control width
  // Status field positions
  localparam int ST_BUSY   = 0; // Concurrent section busy
  localparam int ST_ACTIVE = 1; // Erase or write running
  localparam int ST_HALT   = 2; // Core halted
  localparam int ST_FUSE   = 4; // Boot size fuses, two bits
  localparam int ST_LOCK   = 8; // Lock sets, four bits
  // Interrupt event positions
  localparam int EV_DONE   = 0; // Erase or write finished
  localparam int EV_REJECT = 1; // Store instruction refused
  localparam int EV_W      = 2; // Event count
  // Reset values
  localparam logic [CTRL_W-1:0] CTRL_RST = 5'h00; // Nothing armed
  localparam logic [3:0]        LOCK_RST = 4'hF;  // Unprogrammed locks
  localparam logic [EV_W-1:0]   MASK_RST = 2'h0;  // All masked
  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0; // Good access
  localparam logic [1:0] RESP_DECERR = 2'h3; // Unmapped offset
  // Timing
  localparam int CLK_MHZ     = 100;  // Core clock rate
  localparam int PROG_TIME_US = 4000; // Erase or write time, microseconds
  localparam int PROG_CYCLES = PROG_TIME_US * CLK_MHZ; // Cycles per operation
  // Store instruction carried from the core
  typedef struct packed {
    logic [15:0] pc;   // Word address of executing instruction
    logic [15:0] z;    // Target word address
    logic [7:0]  data; // Lock data for lock programming
  } fsp_store_t;
  // Command to the flash array
  typedef struct packed {
    logic        erase; // Page erase strobe
    logic        write; // Page write strobe
    logic [15:0] addr;  // Target word address
  } fsp_flash_cmd_t;
endpackage
`default_nettype wire

// [hdl/fsp_op_timer.sv]
// Programming time counter for one erase or write
`timescale 1ns/1ps
`default_nettype none
module fsp_op_timer #(
  parameter int CYCLES = 16 // Duration in clock cycles
) (
  input  wire logic clk,     // Core clock
  input  wire logic sys_rst, // Synchronous reset
  input  wire logic start,   // Begin an operation
  output logic      done     // One-cycle finish pulse
);
  localparam int CW = $clog2(CYCLES + 1); // Counter width

  // Refuse unusable lengths at elaboration
  if (CYCLES < 1)
  begin : gBadCycles
    $error("CYCLES must be at least one");
  end

  logic [CW-1:0] count; // Remaining cycles
  logic          run;   // Counting

  // Count down and pulse at the end
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      count <= '0;
      run   <= 1'b0;
      done  <= 1'b0;
    end
    else if (start && !run)
    begin
      count <= CW'(CYCLES - 1);
      run   <= 1'b1;
      done  <= 1'b0;
    end
    else if (run && count == '0)
    begin
      run  <= 1'b0;
      done <= 1'b1;
    end
    else
    begin
      if (run)
        count <= count - 1'b1;
      done <= 1'b0;
    end
  end
endmodule // fsp_op_timer
`default_nettype wire

// [tb/fsp_section_chk.sv]
// Port-level assertions for the section controller
`timescale 1ns/1ps
`default_nettype none
module fsp_section_chk #(
  parameter int PROG_CYCLES = 8 // Operation length
) (
  input wire logic                    clk,     // Core clock
  input wire logic                    sys_rst, // Sync reset
  input wire logic                    storeValid, // Store pulse
  input wire fsp_pkg::fsp_store_t     storeInsn,  // Store fields
  input wire logic                    coreHalt, // Core stall
  input wire logic                    concurrentSectionBusy, // Busy
  input wire fsp_pkg::fsp_flash_cmd_t flashCmd, // Array command
  input wire logic                    irq      // Interrupt
);
  localparam logic [15:0] STALL = 16'h3800; // Stalling base
  localparam int HMAX = PROG_CYCLES + 3; // Latest release
  wire logic strobe; // Erase or write issued
  wire logic busy;   // Short alias
  assign strobe = flashCmd.erase | flashCmd.write;
  assign busy = concurrentSectionBusy;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Store outside any boot size never acts
  app_store_inert_a: assert property
    (storeValid && storeInsn.pc < STALL |=> !strobe)
    else $error("store from application section acted");
  stall_halts_a: assert property
    (strobe && flashCmd.addr >= STALL |-> coreHalt)
    else $error("stalling target did not halt");
  conc_runs_a: assert property
    (strobe && flashCmd.addr < STALL |-> !coreHalt && busy)
    else $error("concurrent target halted or not busy");
  halt_holds_a: assert property ($rose(coreHalt) |-> coreHalt [*8])
    else $error("halt dropped early");
  halt_release_a: assert property ($rose(coreHalt) |-> ##[PROG_CYCLES:HMAX] !coreHalt)
    else $error("halt not released");
  busy_cause_a: assert property ($rose(busy) |-> strobe && flashCmd.addr < STALL)
    else $error("busy rose without concurrent operation");
  busy_holds_a: assert property (busy && !storeValid |=> busy)
    else $error("busy cleared without store");
  halt_quiet_a: assert property (coreHalt && $past(coreHalt) |-> !strobe)
    else $error("command issued while halted");
  cmd_cause_a: assert property
    (strobe |-> $past(storeValid) && $past(storeInsn.pc) >= STALL)
    else $error("command without boot store");
  cover property ($rose(coreHalt));
  cover property ($fell(busy));
  cover property ($rose(irq));
endmodule // fsp_section_chk
`default_nettype wire

// [tb/fsp_core_model.sv]
// Core model issuing store-program instructions
`timescale 1ns/1ps
`default_nettype none
module fsp_core_model (
  input  wire logic           clk,        // Core clock
  input  wire logic           coreHalt,   // Stall from block
  output logic                storeValid, // Store pulse
  output fsp_pkg::fsp_store_t storeInsn   // Store fields
);
  // Idle at time zero
  initial
  begin
    storeValid = 1'b0;
    storeInsn  = 40'h0;
  end
  // One store after gap cycles while the core runs
  // No fetch or interrupt path: busy section never read
  task store(input logic [15:0] pc, z, input logic [7:0] d, input int gap);
    int n;
    n = 0;
    while (coreHalt && n < 200)
    begin
      @(posedge clk);
      n++;
    end
    if (n >= 200)
      testbench.tmo("core halt");
    repeat (gap) @(posedge clk);
    @(posedge clk);
    storeValid <= 1'b1;
    storeInsn  <= {pc, z, d};
    @(posedge clk);
    storeValid <= 1'b0;
    storeInsn  <= ~{pc, z, d}; // Stale fields scrambled
  endtask
endmodule // fsp_core_model
`default_nettype wire

// [tb/testbench.sv]
// Self-checking bench for the section controller
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        clk, sys_rst;        // Clock, reset
  logic [4:0]  awaddr, araddr;      // Bus addresses
  logic        awvalid, wvalid;     // Write valids
  logic        bready, arvalid, rready; // Other strobes
  logic [31:0] wdata, rdata, rd;    // Data, last read
  logic        awready, wready, bvalid; // Write answers
  logic        arready, rvalid;     // Read answers
  logic [1:0]  bresp, rresp, fuses; // Responses, fuses
  logic        storeValid, coreHalt, busy, irq; // Core side
  fsp_pkg::fsp_store_t     storeInsn; // Store fields
  fsp_pkg::fsp_flash_cmd_t cmd;     // Array command
  int          mismatches, n_tests; // Counters
  fsp_section_ctrl #(.PROG_CYCLES(8)) u_fsp_section_ctrl (
    .clk(clk), .sys_rst(sys_rst), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .storeValid(storeValid), .storeInsn(storeInsn), .bootSizeFuses(fuses),
    .coreHalt(coreHalt), .concurrentSectionBusy(busy),
    .flashCmd(cmd), .irq(irq));
  fsp_core_model u_fsp_core_model (.clk(clk), .coreHalt(coreHalt),
    .storeValid(storeValid), .storeInsn(storeInsn));
  // Free-running clock
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Compare and count
  task automatic check(input string nm, input logic [31:0] seen, exp);
    n_tests++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Counts and verdict
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Wait limit used up
  task automatic tmo(input string nm);
    $display("Error %s wait timed out", nm);
    mismatches++;
    give_verdict();
  endtask
  // Bus write, address and data together
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end
    while (!bvalid && n < 50);
    if (n >= 50) tmo("write");
    check("bresp", bresp, a > 5'h0C ? fsp_pkg::RESP_DECERR
                                    : fsp_pkg::RESP_OKAY);
  endtask
  // Bus read, result in rd, response judged
  task automatic rc(input logic [4:0] a, input logic [31:0] e, string nm);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
      if (arready) arvalid <= 1'b0;
    end
    while (!rvalid && n < 50);
    if (n >= 50) tmo("read");
    rd = rdata;
    check("rresp", rresp, a > 5'h0C ? fsp_pkg::RESP_DECERR
                                    : fsp_pkg::RESP_OKAY);
    check(nm, rd, e);
  endtask
  // Arm control, issue store, settle past answer edge
  task automatic st(input logic [4:0] c, input logic [15:0] pc, z,
                    input logic [7:0] d);
    wr(fsp_pkg::REG_CTRL, {27'h0, c});
    u_fsp_core_model.store(pc, z, d, 1);
    @(posedge clk); // Strobes sampled while they stand
  endtask
  // Count halted cycles until release
  task automatic halt_len(output int n);
    n = 0;
    while (coreHalt && n < 50)
    begin
      @(posedge clk);
      n++;
    end
  endtask
  // Reset with given fuse pins
  task automatic do_reset(input logic [1:0] f);
    fuses <= f;
    sys_rst <= 1'b1;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (5) @(posedge clk);
  endtask
  // Reset values, read-only status, unmapped offset
  task automatic t_regs();
    rc(fsp_pkg::REG_STATUS, 32'h00000F30, "status");
    rc(fsp_pkg::REG_IRQ_MASK, 32'h0, "mask");
    wr(fsp_pkg::REG_STATUS, 32'hFFFFFFFF);
    rc(fsp_pkg::REG_STATUS, 32'h00000F30, "status ro");
    rc(5'h10, 32'h0, "unmapped");
    wr(5'h10, 32'h0); // Unmapped write answers with an error
    $display("regs done");
  endtask
  // Application store refused; masked then raised interrupt
  task automatic t_reject();
    st(5'h03, 16'h0100, 16'h3F80, 8'h00);
    check("app erase", cmd.erase, 1'b0);
    check("irq masked", irq, 1'b0);
    rc(fsp_pkg::REG_CTRL, 32'h0, "ctrl cleared");
    wr(fsp_pkg::REG_IRQ_MASK, 32'h3);
    @(posedge clk);
    check("irq", irq, 1'b1);
    rc(fsp_pkg::REG_IRQ_STAT, 32'h2, "reject");
    rc(fsp_pkg::REG_IRQ_STAT, 32'h0, "cleared");
    check("irq cleared", irq, 1'b0);
    $display("reject done");
  endtask
  // Boot erases itself: halted for the whole operation
  task automatic t_halt();
    int n;
    st(5'h03, 16'h3F00, 16'h3F80, 8'h00);
    check("erase", cmd.erase, 1'b1);
    check("addr", cmd.addr, 16'h3F80);
    check("halt", coreHalt, 1'b1);
    check("no busy", busy, 1'b0);
    halt_len(n);
    check("halt len", n >= 8 && n <= 10, 1'b1);
    rc(fsp_pkg::REG_IRQ_STAT, 32'h1, "done");
    $display("halt done");
  endtask
  // Concurrent write, busy held, read enable and page load clear it
  task automatic t_conc();
    st(5'h05, 16'h3F00, 16'h0040, 8'h00);
    check("write", cmd.write, 1'b1);
    check("runs", coreHalt, 1'b0);
    check("busy", busy, 1'b1);
    repeat (12) @(posedge clk);
    rc(fsp_pkg::REG_STATUS, 32'h00000F31, "busy held");
    rc(fsp_pkg::REG_IRQ_STAT, 32'h1, "done");
    st(5'h11, 16'h3F00, 16'h0000, 8'h00);
    check("read enable", busy, 1'b0);
    st(5'h03, 16'h3F00, 16'h0040, 8'h00);
    check("busy again", busy, 1'b1);
    repeat (12) @(posedge clk);
    st(5'h01, 16'h3F00, 16'h0040, 8'h00);
    check("page load", busy, 1'b0);
    check("load no cmd", cmd.write | cmd.erase, 1'b0);
    rc(fsp_pkg::REG_IRQ_STAT, 32'h1, "done");
    $display("conc done");
  endtask
  // Application lock set leaves boot section writable
  task automatic t_lock();
    int n;
    st(5'h09, 16'h3F00, 16'h3F00, 8'h38);
    rc(fsp_pkg::REG_STATUS, 32'h00000E30, "locks");
    st(5'h03, 16'h3F00, 16'h0040, 8'h00);
    check("app locked", cmd.erase, 1'b0);
    rc(fsp_pkg::REG_IRQ_STAT, 32'h2, "reject");
    st(5'h03, 16'h3F00, 16'h3F80, 8'h00);
    check("boot open", cmd.erase, 1'b1);
    halt_len(n);
    check("lock halt len", n >= 8 && n <= 10, 1'b1);
    $display("lock done");
  endtask
  // Largest boot size: boundary follows fuses, still stalling
  task automatic t_fuse();
    int n;
    do_reset(2'h0);
    rc(fsp_pkg::REG_STATUS, 32'h00000F00, "fuse");
    st(5'h03, 16'h3800, 16'h3800, 8'h00);
    check("fuse boot", cmd.erase, 1'b1);
    check("boot stalls", coreHalt, 1'b1);
    halt_len(n);
    check("fuse halt len", n >= 8 && n <= 10, 1'b1);
    $display("fuse done");
  endtask
  // Main sequence
  initial
  begin
    mismatches = 0;
    n_tests = 0;
    {awaddr, araddr, wdata} = 42'h0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h05; // Answers taken
    fuses = 2'h3;
    sys_rst = 1'b1;
    do_reset(2'h3);
    t_regs();
    t_reject();
    t_halt();
    t_conc();
    t_lock();
    t_fuse();
    give_verdict();
  end
endmodule // testbench
bind fsp_section_ctrl fsp_section_chk #(.PROG_CYCLES(PROG_CYCLES))
  u_fsp_section_chk (.clk(clk), .sys_rst(sys_rst), .storeValid(storeValid),
  .storeInsn(storeInsn), .coreHalt(coreHalt), .flashCmd(flashCmd), .irq(irq),
  .concurrentSectionBusy(concurrentSectionBusy));
`default_nettype wire
